// ==== src/alu_pkg.sv ====
// Shared types and constants for the byte/word transfer and ALU datapath
//--------------------------------------------------------------------
//--------------------------------------------------------------------
package alu_pkg;

	typedef enum logic [4:0] {
		OP_TRANSFER = 5'h00,
		OP_PUSH = 5'h01,
		OP_POP = 5'h02,
		OP_ADD = 5'h03,
		OP_SUB = 5'h04,
		OP_SUM_CARRY = 5'h05,
		OP_DIFF_BORROW = 5'h06,
		OP_BUMP_UP = 5'h07,
		OP_COUNT_DOWN = 5'h08,
		OP_WORD_INC = 5'h09,
		OP_WORD_DEC = 5'h0A,
		OP_BCD_SUM = 5'h0B,
		OP_BCD_DIFF = 5'h0C,
		OP_PRODUCT = 5'h0D,
		OP_QUOTIENT = 5'h0E,
		OP_COMPARE = 5'h0F,
		OP_NEGATE = 5'h10,
		OP_AND = 5'h11,
		OP_OR = 5'h12,
		OP_XOR = 5'h13,
		OP_NOT = 5'h14
	} op_t;

	typedef enum logic [2:0] {
		MODE_REG = 3'h0,
		MODE_INDIRECT = 3'h1,
		MODE_DISP16 = 3'h2,
		MODE_ABS16 = 3'h3,
		MODE_ABS8 = 3'h4,
		MODE_IMM = 3'h5,
		MODE_PREDEC = 3'h6,
		MODE_POSTINC = 3'h7
	} mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_MEM = 2'h1,
		ST_DIV = 2'h3,
		ST_DONE = 2'h2
	} state_t;

	// Flag register bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_V = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_N = 3;
	localparam int FLAG_H = 5;

	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [7:0] ABS8_PAGE = 8'hFF;
	localparam logic [2:0] STACK_REG_NUM = 3'h7;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
	localparam logic [7:0] BCD_LOW_FIX = 8'h06;
	localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
	localparam int DIV_WIDTH = 8;

endpackage : alu_pkg

// ==== src/alu_divider.sv ====
// Iterative restoring divider, one quotient bit per clock
module alu_divider
	import alu_pkg::*;
#(
	parameter int W = DIV_WIDTH
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// Request
	input wire logic start_in,
	input wire logic [2*W-1:0] dividend_in,
	input wire logic [W-1:0] divisor_in,
	// Answer
	output logic done_out,
	output logic [W-1:0] quot_out,
	output logic [W-1:0] rem_out
);

	localparam int CW = $clog2(2 * W + 1);

	generate
		if (W < 2) begin : g_bad_width
			$error("alu_divider: W must be at least 2");
		end
	endgenerate

	logic [2*W-1:0] dvd_r;
	logic [W:0] rem_r;
	logic [W-1:0] dsr_r;
	logic [CW-1:0] cnt_r;
	logic busy_r;
	logic [W:0] trial;
	logic fits;
	logic [W:0] rem_nxt;
	logic last;

	assign trial = {rem_r[W-1:0], dvd_r[2*W-1]};
	assign fits = trial >= {1'b0, dsr_r};
	assign rem_nxt = fits ? trial - {1'b0, dsr_r} : trial;
	assign last = cnt_r == CW'(2 * W - 1);

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			dvd_r <= '0;
			rem_r <= '0;
			dsr_r <= '0;
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_out <= 1'b0;
			quot_out <= '0;
			rem_out <= '0;
		end else begin
			done_out <= 1'b0;
			if (start_in && !busy_r) begin
				dvd_r <= dividend_in;
				dsr_r <= divisor_in;
				rem_r <= '0;
				cnt_r <= '0;
				busy_r <= 1'b1;
			end else if (busy_r) begin
				dvd_r <= {dvd_r[2*W-2:0], fits};
				rem_r <= rem_nxt;
				cnt_r <= cnt_r + CW'(1);
				if (last) begin
					busy_r <= 1'b0;
					done_out <= 1'b1;
					// Quotient wider than W is truncated
					quot_out <= {dvd_r[W-2:0], fits};
					rem_out <= rem_nxt[W-1:0];
				end
			end
		end
	end

endmodule : alu_divider

// ==== src/byte_word_alu_transfer.sv ====
// Execution datapath for transfer, arithmetic and logic instructions
module byte_word_alu_transfer
	import alu_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// Decoded instruction
	input wire logic start_in,
	input wire op_t op_in,
	input wire logic word_in,
	input wire mode_t mode_in,
	input wire logic to_mem_in,
	input wire logic use_imm_in,
	input wire logic [2:0] areg_num_in,
	// Operands
	input wire logic [15:0] dst_in,
	input wire logic [15:0] src_in,
	input wire logic [15:0] imm_in,
	input wire logic [15:0] areg_in,
	input wire logic [15:0] disp_in,
	input wire logic [7:0] flags_in,
	// Data memory port
	input wire logic mem_ack_in,
	input wire logic [15:0] mem_rdata_in,
	output logic mem_req_out,
	output logic mem_we_out,
	output logic mem_word_out,
	output logic [15:0] mem_addr_out,
	output logic [15:0] mem_wdata_out,
	// Results
	output logic done_out,
	output logic illegal_out,
	output logic [15:0] result_out,
	output logic result_we_out,
	output logic [7:0] flags_out,
	output logic flags_we_out,
	output logic [15:0] areg_out,
	output logic areg_we_out
);

	state_t state_r, state_nxt;
	logic is_word_r;
	logic load_r;
	logic [15:0] areg_upd_r;
	logic areg_upd_we_r;

	//--------------------------------------------------------------
	// Operand selection and legality
	//--------------------------------------------------------------
	wire is_xfer = op_in == OP_TRANSFER || op_in == OP_PUSH || op_in == OP_POP;
	wire mode_word = (op_in == OP_PUSH || op_in == OP_POP) ? 1'b1 : word_in;
	wire mode_t eff_mode = op_in == OP_PUSH ? MODE_PREDEC :
		op_in == OP_POP ? MODE_POSTINC : mode_in;
	wire xfer_store = op_in == OP_PUSH ? 1'b1 : op_in == OP_POP ? 1'b0 : to_mem_in;
	wire [15:0] operand_b = use_imm_in ? imm_in : src_in;

	wire ill_abs8 = op_in == OP_TRANSFER && mode_in == MODE_ABS8 && word_in;
	wire ill_stack = op_in == OP_TRANSFER && !word_in && areg_num_in == STACK_REG_NUM &&
		(mode_in == MODE_PREDEC || mode_in == MODE_POSTINC);
	wire ill_imm_store = op_in == OP_TRANSFER && mode_in == MODE_IMM && to_mem_in;
	wire ill_sub_imm = op_in == OP_SUB && use_imm_in;
	wire ill_word_imm = word_in && use_imm_in &&
		(op_in == OP_ADD || op_in == OP_COMPARE);
	wire ill_small = (op_in == OP_WORD_INC || op_in == OP_WORD_DEC) &&
		imm_in != STEP_BYTE && imm_in != STEP_WORD;
	wire illegal = ill_abs8 || ill_stack || ill_imm_store || ill_sub_imm ||
		ill_word_imm || ill_small;

	//--------------------------------------------------------------
	// Effective address
	//--------------------------------------------------------------
	wire [15:0] step = mode_word ? STEP_WORD : STEP_BYTE;
	wire [15:0] areg_dec = areg_in - step;
	wire [15:0] areg_inc = areg_in + step;
	logic [15:0] ea_raw;
	always_comb begin
		case (eff_mode)
			MODE_INDIRECT: ea_raw = areg_in;
			MODE_DISP16: ea_raw = areg_in + disp_in;
			MODE_ABS16: ea_raw = imm_in;
			MODE_ABS8: ea_raw = {ABS8_PAGE, imm_in[7:0]};
			MODE_PREDEC: ea_raw = areg_dec;
			MODE_POSTINC: ea_raw = areg_in;
			default: ea_raw = areg_in;
		endcase
	end
	wire [15:0] ea = mode_word ? {ea_raw[15:1], 1'b0} : ea_raw;
	wire needs_mem = is_xfer && eff_mode != MODE_REG && eff_mode != MODE_IMM;
	wire auto_mode = eff_mode == MODE_PREDEC || eff_mode == MODE_POSTINC;
	wire [15:0] areg_new = eff_mode == MODE_PREDEC ? areg_dec : areg_inc;

	//--------------------------------------------------------------
	// Adder shared by add, subtract, compare, negate, step ops
	//--------------------------------------------------------------
	logic [15:0] add_a, add_b;
	logic add_cin, add_sub;
	always_comb begin
		add_a = dst_in;
		add_b = operand_b;
		add_cin = 1'b0;
		add_sub = 1'b0;
		case (op_in)
			OP_SUB, OP_COMPARE: begin
				add_sub = 1'b1;
			end
			OP_SUM_CARRY: add_cin = flags_in[FLAG_C];
			OP_DIFF_BORROW: begin
				add_sub = 1'b1;
				add_cin = flags_in[FLAG_C];
			end
			OP_BUMP_UP: add_b = STEP_BYTE;
			OP_COUNT_DOWN: begin
				add_b = STEP_BYTE;
				add_sub = 1'b1;
			end
			OP_WORD_INC: add_b = imm_in;
			OP_WORD_DEC: begin
				add_b = imm_in;
				add_sub = 1'b1;
			end
			OP_NEGATE: begin
				add_a = 16'h0000;
				add_b = dst_in;
				add_sub = 1'b1;
			end
			default: add_cin = 1'b0;
		endcase
	end
	// Subtract as a + ~b + 1 - borrow; carry flag is the inverted carry out
	wire [15:0] b_eff = add_sub ? ~add_b : add_b;
	wire c_in_eff = add_sub ? ~add_cin : add_cin;
	wire op_word = word_in && (op_in == OP_ADD || op_in == OP_SUB || op_in == OP_COMPARE) ||
		op_in == OP_WORD_INC || op_in == OP_WORD_DEC;
	wire [8:0] sum9 = {1'b0, add_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, c_in_eff};
	wire [16:0] sum17 = {1'b0, add_a} + {1'b0, b_eff} + {16'h0000, c_in_eff};
	wire [4:0] nib_lo = {1'b0, add_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_in_eff};
	wire [12:0] nib_w = {1'b0, add_a[11:0]} + {1'b0, b_eff[11:0]} + {12'h000, c_in_eff};
	wire [15:0] sum = op_word ? sum17[15:0] : {8'h00, sum9[7:0]};
	wire sum_c = (op_word ? sum17[16] : sum9[8]) ^ add_sub;
	wire sum_h = (op_word ? nib_w[12] : nib_lo[4]) ^ add_sub;
	wire a_msb = op_word ? add_a[15] : add_a[7];
	wire b_msb = op_word ? b_eff[15] : b_eff[7];
	wire s_msb = op_word ? sum[15] : sum[7];
	wire sum_v = a_msb == b_msb && s_msb != a_msb;

	//--------------------------------------------------------------
	// Decimal adjust
	//--------------------------------------------------------------
	wire [7:0] bcd_val = dst_in[7:0];
	wire bcd_lo_fix = flags_in[FLAG_H] || bcd_val[3:0] > BCD_DIGIT_MAX;
	wire bcd_hi_fix = flags_in[FLAG_C] || bcd_val > BCD_BYTE_MAX;
	wire [7:0] daa_fix = (bcd_lo_fix ? BCD_LOW_FIX : 8'h00) | (bcd_hi_fix ? BCD_HIGH_FIX : 8'h00);
	wire [7:0] das_fix = (flags_in[FLAG_H] ? BCD_LOW_FIX : 8'h00) |
		(flags_in[FLAG_C] ? BCD_HIGH_FIX : 8'h00);
	wire [7:0] daa_res = bcd_val + daa_fix;
	wire [7:0] das_res = bcd_val - das_fix;

	wire [15:0] product = {8'h00, dst_in[7:0]} * {8'h00, src_in[7:0]};

	//--------------------------------------------------------------
	// Result and flag selection
	//--------------------------------------------------------------
	logic [15:0] res;
	logic res_we;
	logic [7:0] fl;
	logic fl_we;
	logic nz_upd;
	wire [15:0] xfer_val = eff_mode == MODE_IMM ? imm_in : src_in;
	always_comb begin
		res = sum;
		res_we = 1'b1;
		fl = flags_in;
		fl_we = 1'b1;
		nz_upd = 1'b1;
		case (op_in)
			OP_TRANSFER, OP_PUSH, OP_POP: begin
				res = mode_word ? xfer_val : {8'h00, xfer_val[7:0]};
				fl[FLAG_V] = 1'b0;
			end
			OP_ADD, OP_SUB, OP_NEGATE: begin
				fl[FLAG_H] = sum_h;
				fl[FLAG_V] = sum_v;
				fl[FLAG_C] = sum_c;
			end
			OP_SUM_CARRY, OP_DIFF_BORROW: begin
				fl[FLAG_H] = sum_h;
				fl[FLAG_V] = sum_v;
				fl[FLAG_C] = sum_c;
				nz_upd = 1'b0;
				fl[FLAG_N] = sum[7];
				// Zero only stays set, so multi-byte chains test the whole value
				fl[FLAG_Z] = flags_in[FLAG_Z] && sum[7:0] == 8'h00;
			end
			OP_BUMP_UP, OP_COUNT_DOWN: fl[FLAG_V] = sum_v;
			OP_WORD_INC, OP_WORD_DEC: begin
				fl_we = 1'b0;
				nz_upd = 1'b0;
			end
			OP_COMPARE: begin
				res_we = 1'b0;
				fl[FLAG_H] = sum_h;
				fl[FLAG_V] = sum_v;
				fl[FLAG_C] = sum_c;
			end
			OP_BCD_SUM: begin
				res = {8'h00, daa_res};
				fl[FLAG_C] = bcd_hi_fix;
			end
			OP_BCD_DIFF: res = {8'h00, das_res};
			OP_PRODUCT: begin
				res = product;
				fl_we = 1'b0;
				nz_upd = 1'b0;
			end
			OP_AND: begin
				res = {8'h00, dst_in[7:0] & operand_b[7:0]};
				fl[FLAG_V] = 1'b0;
			end
			OP_OR: begin
				res = {8'h00, dst_in[7:0] | operand_b[7:0]};
				fl[FLAG_V] = 1'b0;
			end
			OP_XOR: begin
				res = {8'h00, dst_in[7:0] ^ operand_b[7:0]};
				fl[FLAG_V] = 1'b0;
			end
			OP_NOT: begin
				res = {8'h00, ~dst_in[7:0]};
				fl[FLAG_V] = 1'b0;
			end
			default: begin
				res_we = 1'b0;
				fl_we = 1'b0;
			end
		endcase
		if (nz_upd) begin
			fl[FLAG_N] = op_word || (is_xfer && mode_word) ? res[15] : res[7];
			fl[FLAG_Z] = op_word || (is_xfer && mode_word) ? res == 16'h0000 :
				res[7:0] == 8'h00;
		end
	end

	//--------------------------------------------------------------
	// Divider
	//--------------------------------------------------------------
	wire div_start = state_r == ST_IDLE && start_in && !illegal && op_in == OP_QUOTIENT;
	logic div_done;
	logic [7:0] div_quot, div_rem;
	alu_divider #(.W(DIV_WIDTH)) u_divider (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.start_in(div_start),
		.dividend_in(dst_in),
		.divisor_in(src_in[7:0]),
		.done_out(div_done),
		.quot_out(div_quot),
		.rem_out(div_rem)
	);
	logic div_n_r, div_z_r;
	logic [7:0] div_flags_base_r;

	//--------------------------------------------------------------
	// Sequencer
	//--------------------------------------------------------------
	wire take = state_r == ST_IDLE && start_in;
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_in && !illegal && needs_mem)
					state_nxt = ST_MEM;
				else if (div_start)
					state_nxt = ST_DIV;
				else if (start_in)
					state_nxt = ST_DONE;
			end
			ST_MEM: if (mem_ack_in) state_nxt = ST_DONE;
			ST_DIV: if (div_done) state_nxt = ST_DONE;
			ST_DONE: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	wire [15:0] load_val = is_word_r ? mem_rdata_in : {8'h00, mem_rdata_in[7:0]};
	wire load_n = is_word_r ? mem_rdata_in[15] : mem_rdata_in[7];
	wire load_z = is_word_r ? mem_rdata_in == 16'h0000 : mem_rdata_in[7:0] == 8'h00;

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_r <= ST_IDLE;
			is_word_r <= 1'b0;
			load_r <= 1'b0;
			areg_upd_r <= 16'h0000;
			areg_upd_we_r <= 1'b0;
			div_n_r <= 1'b0;
			div_z_r <= 1'b0;
			div_flags_base_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			if (take) begin
				is_word_r <= mode_word;
				load_r <= !xfer_store;
				areg_upd_r <= areg_new;
				areg_upd_we_r <= needs_mem && auto_mode;
				div_n_r <= src_in[7];
				div_z_r <= src_in[7:0] == 8'h00;
				div_flags_base_r <= flags_in;
			end
		end
	end

	// Memory request: stands from the cycle after take until acknowledged
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			mem_req_out <= 1'b0;
			mem_we_out <= 1'b0;
			mem_word_out <= 1'b0;
			mem_addr_out <= 16'h0000;
			mem_wdata_out <= 16'h0000;
		end else if (take && !illegal && needs_mem) begin
			mem_req_out <= 1'b1;
			mem_we_out <= xfer_store;
			mem_word_out <= mode_word;
			mem_addr_out <= ea;
			mem_wdata_out <= mode_word ? src_in : {8'h00, src_in[7:0]};
		end else if (state_r == ST_MEM && mem_ack_in) begin
			mem_req_out <= 1'b0;
			mem_we_out <= 1'b0;
		end
	end

	// Completion strobes; all one-cycle pulses
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			done_out <= 1'b0;
			illegal_out <= 1'b0;
			result_out <= 16'h0000;
			result_we_out <= 1'b0;
			flags_out <= 8'h00;
			flags_we_out <= 1'b0;
			areg_out <= 16'h0000;
			areg_we_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			illegal_out <= 1'b0;
			result_we_out <= 1'b0;
			flags_we_out <= 1'b0;
			areg_we_out <= 1'b0;
			if (take && (illegal || (!needs_mem && op_in != OP_QUOTIENT))) begin
				done_out <= 1'b1;
				illegal_out <= illegal;
				result_out <= res;
				result_we_out <= res_we && !illegal;
				flags_out <= fl;
				flags_we_out <= fl_we && !illegal;
			end else if (state_r == ST_MEM && mem_ack_in) begin
				done_out <= 1'b1;
				result_out <= load_val;
				result_we_out <= load_r;
				flags_out <= (div_flags_base_r & ~8'h0E) |
					{4'h0, load_n, load_z, 2'b00};
				flags_we_out <= 1'b1;
				areg_out <= areg_upd_r;
				areg_we_out <= areg_upd_we_r;
			end else if (state_r == ST_DIV && div_done) begin
				done_out <= 1'b1;
				result_out <= {div_rem, div_quot};
				result_we_out <= 1'b1;
				flags_out <= (div_flags_base_r & ~8'h0C) |
					{4'h0, div_n_r, div_z_r, 2'b00};
				flags_we_out <= 1'b1;
			end
		end
	end

endmodule : byte_word_alu_transfer

// ==== test/byte_word_alu_transfer_props.sv ====
// Concurrent checks on the datapath ports
module byte_word_alu_transfer_props
	import alu_pkg::*;
(
	// Watched inputs
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic start_in,
	input wire op_t op_in,
	input wire logic [15:0] dst_in,
	input wire logic [15:0] src_in,
	input wire logic [15:0] imm_in,
	input wire logic [15:0] areg_in,
	input wire logic mem_ack_in,
	// Watched outputs
	input wire logic mem_req_out,
	input wire logic mem_we_out,
	input wire logic mem_word_out,
	input wire logic [15:0] mem_addr_out,
	input wire logic done_out,
	input wire logic illegal_out,
	input wire logic [15:0] result_out,
	input wire logic result_we_out,
	input wire logic flags_we_out,
	input wire logic areg_we_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	logic go_w;
	assign go_w = start_in;

	property p_word_even;
		mem_req_out && mem_word_out |-> !mem_addr_out[0];
	endproperty
	a_word_even: assert property (p_word_even) else $error("odd word address");
	property p_req_hold;
		mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped");
	property p_ack_done;
		mem_req_out && mem_ack_in |=> done_out && !mem_req_out;
	endproperty
	a_ack_done: assert property (p_ack_done) else $error("no finish after ack");
	property p_refuse;
		illegal_out |-> done_out && !result_we_out && !flags_we_out && !areg_we_out;
	endproperty
	a_refuse: assert property (p_refuse) else $error("refused op wrote");
	property p_cmp;
		go_w && op_in == OP_COMPARE |=> done_out && !result_we_out;
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare wrote register");
	property p_neg;
		go_w && op_in == OP_NEGATE |=> result_we_out && result_out == {8'h00, 8'h00 - $past(dst_in[7:0])};
	endproperty
	a_neg: assert property (p_neg) else $error("negate wrong");
	property p_not;
		go_w && op_in == OP_NOT |=> result_out == {8'h00, ~$past(dst_in[7:0])};
	endproperty
	a_not: assert property (p_not) else $error("invert wrong");
	property p_prod;
		go_w && op_in == OP_PRODUCT |=> result_out == $past(dst_in[7:0]) * $past(src_in[7:0]);
	endproperty
	a_prod: assert property (p_prod) else $error("product wrong");
	property p_div;
		go_w && op_in == OP_QUOTIENT |-> ##18 done_out && result_we_out;
	endproperty
	a_div: assert property (p_div) else $error("divide timing");
	property p_push;
		go_w && op_in == OP_PUSH |=> mem_req_out && mem_we_out && mem_word_out
			&& mem_addr_out == (($past(areg_in) - 16'h0002) & 16'hFFFE);
	endproperty
	a_push: assert property (p_push) else $error("push address");
	property p_winc;
		go_w && op_in == OP_WORD_INC && imm_in inside {16'h0001, 16'h0002}
			|=> result_out == $past(dst_in) + $past(imm_in);
	endproperty
	a_winc: assert property (p_winc) else $error("word step wrong");

	c_div: cover property (go_w && op_in == OP_QUOTIENT);
	c_bad: cover property (illegal_out);
	c_load: cover property (mem_req_out && mem_ack_in && !mem_we_out);
endmodule : byte_word_alu_transfer_props

bind byte_word_alu_transfer byte_word_alu_transfer_props u_props (.ref_clk_in, .reset_in,
	.start_in, .op_in, .dst_in, .src_in, .imm_in, .areg_in, .mem_ack_in, .mem_req_out,
	.mem_we_out, .mem_word_out, .mem_addr_out, .done_out, .illegal_out, .result_out,
	.result_we_out, .flags_we_out, .areg_we_out);

// ==== test/data_mem_model.sv ====
// Behavioural data memory answering the datapath memory port
module data_mem_model (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// Request
	input wire logic req_in,
	input wire logic we_in,
	input wire logic word_in,
	input wire logic [15:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic [1:0] lat_in,
	// Answer
	output logic ack_out,
	output logic [15:0] rdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem_r [0:255];
	logic [1:0] wait_r;
	logic [7:0] a;
	logic hit;
	assign a = addr_in[7:0];
	assign hit = req_in && !ack_out && wait_r == lat_in;
	always @(posedge ref_clk_in) begin
		if (hit && we_in && word_in) begin
			mem_r[a] <= wdata_in[15:8];
			mem_r[a + 8'h01] <= wdata_in[7:0];
		end else if (hit && we_in) begin
			mem_r[a] <= wdata_in[7:0];
		end
	end
	always @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ack_out <= 1'b0;
			wait_r <= 2'h0;
			rdata_out <= 16'h0000;
		end else if (hit) begin
			ack_out <= 1'b1;
			wait_r <= 2'h0;
			rdata_out <= we_in ? wdata_in : word_in ? {mem_r[a], mem_r[a + 8'h01]} : {8'h00, mem_r[a]};
		end else begin
			ack_out <= 1'b0;
			wait_r <= (req_in && !ack_out) ? wait_r + 2'h1 : 2'h0;
			// Idle bus toggles so stale data never looks valid
			rdata_out <= ~rdata_out;
		end
	end
endmodule : data_mem_model

// ==== test/byte_word_alu_transfer_tb.sv ====
// Self-checking bench for the transfer and ALU datapath
module byte_word_alu_transfer_tb import alu_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic start = 1'b0, word = 1'b0, to_mem = 1'b0, use_imm = 1'b0;
	op_t op = OP_ADD;
	mode_t mode = MODE_REG;
	logic [2:0] anum = 3'h0;
	logic [15:0] dst = '0, src = '0, imm = '0, areg = '0, disp = '0, dsp = '0;
	logic [7:0] flags = 8'h00, fl = 8'h00, fout;
	logic [1:0] lat = 2'h0;
	logic ack, req, we, mword, done, bad, rwe, fwe, awe;
	logic [15:0] rdata, addr, wdata, res, aout, last_addr;
	int err_count = 0, cmp_count = 0, seed = 57, nreq = 0;

	byte_word_alu_transfer u_byte_word_alu_transfer (.ref_clk_in(ref_clk_in),
		.reset_in(reset_in), .start_in(start), .op_in(op), .word_in(word), .mode_in(mode),
		.to_mem_in(to_mem), .use_imm_in(use_imm), .areg_num_in(anum), .dst_in(dst),
		.src_in(src), .imm_in(imm), .areg_in(areg), .disp_in(disp), .flags_in(flags),
		.mem_ack_in(ack), .mem_rdata_in(rdata), .mem_req_out(req), .mem_we_out(we),
		.mem_word_out(mword), .mem_addr_out(addr), .mem_wdata_out(wdata), .done_out(done),
		.illegal_out(bad), .result_out(res), .result_we_out(rwe), .flags_out(fout),
		.flags_we_out(fwe), .areg_out(aout), .areg_we_out(awe));
	data_mem_model u_data_mem_model (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.req_in(req), .we_in(we), .word_in(mword), .addr_in(addr), .wdata_in(wdata),
		.lat_in(lat), .ack_out(ack), .rdata_out(rdata));

	always #5 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) begin
		if (req) begin
			last_addr <= addr;
			nreq++;
		end
	end

	task summarize();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task go(input op_t o, input logic w, input mode_t m, input logic tm, input logic ui,
		input logic [2:0] an, input logic [15:0] d, s, i, a);
		@(posedge ref_clk_in);
		op <= o;
		word <= w;
		mode <= m;
		to_mem <= tm;
		use_imm <= ui;
		anum <= an;
		dst <= d;
		src <= s;
		imm <= i;
		areg <= a;
		flags <= fl;
		disp <= dsp;
		lat <= 2'($random(seed));
		start <= 1'b1;
		@(posedge ref_clk_in);
		start <= 1'b0;
		nreq = 0;
		// Register ops other than divide answer at the take edge
		#1;
		for (int n = 0; n < 40 && done !== 1'b1; n++) begin
			@(posedge ref_clk_in);
			#1;
		end
		chk(16'(done), 16'h0001);
	endtask : go
	task refused();
		chk({12'h000, bad, rwe, fwe, awe}, 16'h0008);
		chk(16'(nreq), 16'h0000);
	endtask : refused
	function automatic logic [15:0] alu_exp(input op_t o, input logic w,
		input logic [15:0] d, input logic [15:0] b, input logic c);
		logic [15:0] q;
		logic [15:0] r;
		q = d / {8'h00, b[7:0]};
		r = d % {8'h00, b[7:0]};
		case (o)
			OP_ADD: return w ? d + b : {8'h00, d[7:0] + b[7:0]};
			OP_SUB: return w ? d - b : {8'h00, d[7:0] - b[7:0]};
			OP_SUM_CARRY: return {8'h00, d[7:0] + b[7:0] + {7'h00, c}};
			OP_DIFF_BORROW: return {8'h00, d[7:0] - b[7:0] - {7'h00, c}};
			OP_BUMP_UP: return {8'h00, d[7:0] + 8'h01};
			OP_COUNT_DOWN: return {8'h00, d[7:0] - 8'h01};
			OP_WORD_INC: return d + b;
			OP_WORD_DEC: return d - b;
			OP_PRODUCT: return d[7:0] * b[7:0];
			OP_NEGATE: return {8'h00, 8'h00 - d[7:0]};
			OP_AND: return {8'h00, d[7:0] & b[7:0]};
			OP_OR: return {8'h00, d[7:0] | b[7:0]};
			OP_XOR: return {8'h00, d[7:0] ^ b[7:0]};
			OP_NOT: return {8'h00, ~d[7:0]};
			default: return {r[7:0], q[7:0]};
		endcase
	endfunction : alu_exp
	function automatic logic [7:0] bcd(input int n);
		return {4'(n / 10), 4'(n % 10)};
	endfunction : bcd

	initial begin
		#100000;
		err_count++;
		$display("FAIL t=%0t watchdog", $time);
		summarize();
	end
	initial begin
		int da, db;
		op_t o;
		logic w, ui;
		logic [15:0] d, b, v, sp;
		repeat (2) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		//--------------------------------------------------
		// Register operations, random then corners
		//--------------------------------------------------
		for (int k = 0; k < 80; k++) begin
			o = op_t'(5'h03 + 5'($unsigned($random(seed)) % 18));
			if (o inside {OP_BCD_SUM, OP_BCD_DIFF})
				o = OP_XOR;
			w = (o inside {OP_ADD, OP_SUB, OP_COMPARE}) ? 1'($random(seed)) : 1'b0;
			ui = !w && o inside {OP_ADD, OP_SUM_CARRY, OP_DIFF_BORROW, OP_COMPARE, OP_AND,
				OP_OR, OP_XOR} ? 1'($random(seed)) : 1'b0;
			d = 16'($random(seed));
			b = 16'($random(seed));
			fl = 8'($random(seed));
			if (o inside {OP_WORD_INC, OP_WORD_DEC}) begin
				w = 1'b1;
				ui = 1'b1;
				b = 16'h0001 + 16'(k % 2);
			end
			if (o == OP_QUOTIENT) begin
				b[7:0] = b[7:0] | 8'h01;
				d[15:8] = d[15:8] % b[7:0];
			end
			go(o, w, MODE_REG, 1'b0, ui, 3'h0, d, ui ? 16'hA5A5 : b, ui ? b : 16'h5A5A, '0);
			chk(16'(bad), 16'h0000);
			if (o == OP_COMPARE) begin
				chk(16'(rwe), 16'h0000);
				chk(16'(fout[FLAG_Z]), 16'(w ? d == b : d[7:0] == b[7:0]));
			end else begin
				chk(res, alu_exp(o, w, d, b, fl[FLAG_C]));
			end
		end
		go(OP_PRODUCT, 1'b0, MODE_REG, 1'b0, 1'b0, 3'h0, 16'h00FF, 16'h00FF, '0, '0);
		chk(res, 16'hFE01);
		go(OP_QUOTIENT, 1'b0, MODE_REG, 1'b0, 1'b0, 3'h0, 16'hFEFF, 16'h00FF, '0, '0);
		chk(res, 16'hFEFF);
		go(OP_NEGATE, 1'b0, MODE_REG, 1'b0, 1'b0, 3'h0, 16'h0080, '0, '0, '0);
		chk(res, 16'h0080);
		$display("test register ops done");
		//--------------------------------------------------
		// Decimal adjust after add and subtract
		//--------------------------------------------------
		for (int k = 0; k < 20; k++) begin
			da = $unsigned($random(seed)) % 100;
			db = $unsigned($random(seed)) % 100;
			d = 16'(bcd(da)) + 16'(bcd(db));
			fl = 8'h00;
			fl[FLAG_H] = (bcd(da) & 8'h0F) + (bcd(db) & 8'h0F) > 8'h0F;
			fl[FLAG_C] = d[8];
			go(OP_BCD_SUM, 1'b0, MODE_REG, 1'b0, 1'b0, 3'h0, d & 16'h00FF, '0, '0, '0);
			chk(res, 16'(bcd((da + db) % 100)));
			d = 16'(bcd(da)) - 16'(bcd(db));
			fl[FLAG_H] = (bcd(da) & 8'h0F) < (bcd(db) & 8'h0F);
			fl[FLAG_C] = da < db;
			go(OP_BCD_DIFF, 1'b0, MODE_REG, 1'b0, 1'b0, 3'h0, d & 16'h00FF, '0, '0, '0);
			chk(res, 16'(bcd((da - db + 100) % 100)));
		end
		$display("test decimal adjust done");
		//--------------------------------------------------
		// Refused requests
		//--------------------------------------------------
		go(OP_TRANSFER, 1'b1, MODE_ABS8, 1'b1, 1'b0, 3'h2, '0, '0, 16'h0010, '0);
		refused();
		go(OP_TRANSFER, 1'b0, MODE_PREDEC, 1'b1, 1'b0, 3'h7, '0, '0, '0, 16'h0040);
		refused();
		go(OP_TRANSFER, 1'b0, MODE_POSTINC, 1'b0, 1'b0, 3'h7, '0, '0, '0, 16'h0040);
		refused();
		go(OP_TRANSFER, 1'b1, MODE_IMM, 1'b1, 1'b1, 3'h2, '0, '0, 16'h1234, '0);
		refused();
		go(OP_SUB, 1'b0, MODE_REG, 1'b0, 1'b1, 3'h0, 16'h0005, '0, 16'h0001, '0);
		refused();
		go(OP_ADD, 1'b1, MODE_REG, 1'b0, 1'b1, 3'h0, 16'h0005, '0, 16'h0001, '0);
		refused();
		go(OP_COMPARE, 1'b1, MODE_REG, 1'b0, 1'b1, 3'h0, 16'h0005, '0, 16'h0005, '0);
		refused();
		go(OP_WORD_INC, 1'b1, MODE_REG, 1'b0, 1'b1, 3'h0, 16'h0005, '0, 16'h0003, '0);
		refused();
		$display("test refusals done");
		//--------------------------------------------------
		// Memory transfers with random latency
		//--------------------------------------------------
		v = 16'($random(seed));
		sp = 16'($random(seed)) & 16'hFFFE;
		go(OP_PUSH, 1'b1, MODE_PREDEC, 1'b1, 1'b0, 3'h7, '0, v, '0, sp);
		chk(aout, sp - 16'h0002);
		go(OP_POP, 1'b1, MODE_POSTINC, 1'b0, 1'b0, 3'h7, '0, '0, '0, sp - 16'h0002);
		chk(res, v);
		chk(aout, sp);
		go(OP_TRANSFER, 1'b0, MODE_PREDEC, 1'b1, 1'b0, 3'h2, '0, v, '0, sp);
		chk(aout, sp - 16'h0001);
		go(OP_TRANSFER, 1'b0, MODE_POSTINC, 1'b0, 1'b0, 3'h2, '0, '0, '0, sp - 16'h0001);
		chk(res, v & 16'h00FF);
		chk(aout, sp);
		dsp = 16'h0031;
		go(OP_TRANSFER, 1'b1, MODE_DISP16, 1'b1, 1'b0, 3'h2, '0, ~v, '0, sp);
		go(OP_TRANSFER, 1'b1, MODE_ABS16, 1'b0, 1'b0, 3'h2, '0, '0, sp + 16'h0031, '0);
		chk(last_addr, sp + 16'h0030);
		chk(res, ~v);
		go(OP_TRANSFER, 1'b0, MODE_ABS8, 1'b1, 1'b0, 3'h2, '0, v, 16'h0042, '0);
		chk(last_addr, 16'hFF42);
		go(OP_TRANSFER, 1'b1, MODE_IMM, 1'b0, 1'b1, 3'h2, '0, '0, v, '0);
		chk(res, v);
		go(OP_TRANSFER, 1'b1, MODE_REG, 1'b0, 1'b0, 3'h2, '0, ~v, '0, '0);
		chk(res, ~v);
		$display("test memory transfers done");
		summarize();
	end
endmodule : byte_word_alu_transfer_tb
